// ==== safety_gate_pkg.sv ====
// What this block does
// - Outside Enable mode, output needs every mapped input in Run
// - Self-check must be Run without fault
// - Latch input return holds output until reset
// - One reset clears latch for all inputs
// - Reset accepted only with mapped inputs Run
// - Both hands active within half a second
// - Two-hand Run transition turns output on last
// - Latched stop blocks two-hand cycles until reset
// - Hands held at power-up must release first
// - Two-hand input never needs a manual reset
// - Enabling switch rising edge enters Enable mode
// - Enable drives outputs given feedback and e-stops
// - Enable mode ignores all but e-stop inputs
// - Enabling switch may cycle repeatedly in mode
// - Exit needs switch off plus system reset
// - Enable time limit always enforced, 1s-30min
// - Limit reloads only on off-then-on switch
// - On and off delays still apply
// - Monitored reset: high 0.3-2 s, trailing edge
// - Non-monitored reset: high at least 0.3 s
package safety_gate_pkg;

    localparam int N_IN = 8;
    localparam int N_OUT = 2;
    localparam int N_FB = 2;

    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Times in milliseconds, counted on the tick
    localparam logic [11:0] TWO_HAND_WINDOW_MS = 12'h1F4;
    localparam logic [11:0] RESET_MIN_MS = 12'h12C;
    localparam logic [11:0] RESET_MAX_MS = 12'h7D0;
    localparam logic [11:0] RESET_SAT_MS = 12'h7D1;
    localparam logic [20:0] EN_LIMIT_MIN_MS = 21'h003E8;
    localparam logic [20:0] EN_LIMIT_MAX_MS = 21'h1B7740;
    localparam logic [20:0] EN_LIMIT_RESET = 21'h02710;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LATCH = 8'h04;
    localparam logic [7:0] ADDR_ESTOP = 8'h08;
    localparam logic [7:0] ADDR_DELAY = 8'h0C;
    localparam logic [7:0] ADDR_EN_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IN_STATE = 8'h18;
    localparam logic [7:0] ADDR_MAP_BASE = 8'h20;

    localparam int CTRL_LATCH_MON_BIT = 0;
    localparam int CTRL_SYS_MON_BIT = 1;
    localparam int DELAY_OFF_LSB = 16;
    localparam int MAP_DUAL_BIT = 8;
    localparam int MAP_ENSW_BIT = 9;
    localparam int MAP_FB_LSB = 10;
    localparam int STATUS_EN_BIT = 8;
    localparam int STATUS_THC_BIT = 9;
    localparam int STATUS_PEND_LSB = 16;
    localparam int IN_HANDS_LSB = 8;
    localparam int IN_ENSW_BIT = 10;
    localparam int IN_FB_LSB = 11;

    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [11:0] MAP_RESET = 12'h0FF;

    typedef enum logic [1:0] {
        THC_WAIT_RELEASE,
        THC_IDLE,
        THC_WINDOW,
        THC_RUN
    } thc_state_t;

    typedef struct packed {
        logic latch_mon;
        logic sys_mon;
        logic [N_IN-1:0] latch;
        logic [N_IN-1:0] estop;
        logic [15:0] on_ms;
        logic [15:0] off_ms;
        logic [20:0] en_limit;
        logic [N_OUT-1:0][11:0] map;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{
        latch_mon: 1'b1,
        sys_mon: 1'b1,
        latch: LATCH_RESET,
        estop: 8'h00,
        on_ms: 16'h0000,
        off_ms: 16'h0000,
        en_limit: EN_LIMIT_RESET,
        map: {N_OUT{MAP_RESET}}
    };

endpackage : safety_gate_pkg

// ==== pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t st;
    sync_t next_st;

    // A bit moves only once the second and third stages agree
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : pin_sync

// ==== safety_output_gate.sv ====
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module safety_output_gate #(
    parameter int TICK_CYCLES = safety_gate_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [safety_gate_pkg::N_IN-1:0] safety_in,
    input wire logic latch_reset_in,
    input wire logic system_reset_in,
    input wire logic hand_a_in,
    input wire logic hand_b_in,
    input wire logic enable_sw_in,
    input wire logic [safety_gate_pkg::N_FB-1:0] contactor_feedback_input,
    input wire logic selfcheck_ok,
    output logic [safety_gate_pkg::N_OUT-1:0] safety_out,
    output logic enable_mode
);
    localparam int NI = safety_gate_pkg::N_IN;
    localparam int NO = safety_gate_pkg::N_OUT;
    localparam int NF = safety_gate_pkg::N_FB;
    localparam int SW = NI + NF + 5;
    localparam int MAP_FB_HI = safety_gate_pkg::MAP_FB_LSB + NF - 1;
    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

    typedef struct packed {
        safety_gate_pkg::cfg_t cfg;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic [19:0] tick_cnt;
        logic [1:0] rst_hi;
        logic [1:0] rst_fired;
        logic [1:0][11:0] rst_ms;
        safety_gate_pkg::thc_state_t dual_actuator_control;
        logic [11:0] thc_ms;
        logic sw_prev;
        logic en_mode;
        logic [20:0] en_left;
        logic [NO-1:0] pending;
        logic [NO-1:0] thc_ok;
        logic [NO-1:0] en_hold;
        logic [NO-1:0] out;
        logic [NO-1:0][15:0] dly_ms;
    } st_t;

    localparam st_t ST_RESET = '{
        cfg: safety_gate_pkg::CFG_RESET,
        dual_actuator_control: safety_gate_pkg::THC_WAIT_RELEASE,
        pending: {NO{1'b1}},
        default: '0
    };

    st_t st;
    st_t next_st;

    logic [SW-1:0] raw_pins;
    logic [SW-1:0] pins;
    logic [NI-1:0] run;
    logic hand_a;
    logic hand_b;
    logic sw_on;
    logic [NF-1:0] fb;
    logic ms_tick;
    logic [1:0] rst_pulse;
    logic rst_lvl;
    logic rst_mon;
    logic thc_enter;
    logic sw_rise;
    logic en_live;
    logic [11:0] map;
    logic all_run;
    logic has_latch;
    logic latch_stop;
    logic normal_ok;
    logic estop_ok;
    logic fb_closed;
    logic demand;
    logic [15:0] target;
    logic [20:0] lim;

    assign raw_pins = {contactor_feedback_input, enable_sw_in, hand_b_in, hand_a_in,
                       system_reset_in, latch_reset_in, safety_in};

    pin_sync #(
        .W(SW)
    ) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(raw_pins),
        .q(pins)
    );

    assign run = pins[NI-1:0];
    assign hand_a = pins[NI+2];
    assign hand_b = pins[NI+3];
    assign sw_on = pins[NI+4];
    assign fb = pins[SW-1:NI+5];

    function automatic logic [31:0] rd_mux(input st_t x, input logic [7:0] a,
                                            input logic [SW-1:0] p);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            safety_gate_pkg::ADDR_CTRL: begin
                r[safety_gate_pkg::CTRL_LATCH_MON_BIT] = x.cfg.latch_mon;
                r[safety_gate_pkg::CTRL_SYS_MON_BIT] = x.cfg.sys_mon;
            end
            safety_gate_pkg::ADDR_LATCH: r[NI-1:0] = x.cfg.latch;
            safety_gate_pkg::ADDR_ESTOP: r[NI-1:0] = x.cfg.estop;
            safety_gate_pkg::ADDR_DELAY: r = {x.cfg.off_ms, x.cfg.on_ms};
            safety_gate_pkg::ADDR_EN_LIMIT: r[20:0] = x.cfg.en_limit;
            safety_gate_pkg::ADDR_STATUS: begin
                r[NO-1:0] = x.out;
                r[safety_gate_pkg::STATUS_EN_BIT] = x.en_mode;
                r[safety_gate_pkg::STATUS_THC_BIT] = (x.dual_actuator_control == safety_gate_pkg::THC_RUN);
                r[safety_gate_pkg::STATUS_PEND_LSB +: NO] = x.pending;
            end
            safety_gate_pkg::ADDR_IN_STATE: begin
                r[NI-1:0] = p[NI-1:0];
                r[safety_gate_pkg::IN_HANDS_LSB +: 2] = p[NI+3:NI+2];
                r[safety_gate_pkg::IN_ENSW_BIT] = p[NI+4];
                r[safety_gate_pkg::IN_FB_LSB +: NF] = p[SW-1:NI+5];
            end
            default: begin
                for (int o = 0; o < NO; o++) begin
                    if (a == safety_gate_pkg::ADDR_MAP_BASE + 8'(4 * o)) begin
                        r[11:0] = x.cfg.map[o];
                    end
                end
            end
        endcase
        return r;
    endfunction : rd_mux

    always_comb begin
        next_st = st;
        rst_pulse = 2'b00;
        rst_lvl = 1'b0;
        rst_mon = 1'b0;
        map = 12'h000;
        all_run = 1'b0;
        has_latch = 1'b0;
        latch_stop = 1'b0;
        normal_ok = 1'b0;
        estop_ok = 1'b0;
        fb_closed = 1'b0;
        demand = 1'b0;
        target = 16'h0000;
        lim = hwdata[20:0];

        // One free-running millisecond tick paces every window and limit
        ms_tick = (st.tick_cnt == TICK_LAST);
        next_st.tick_cnt = ms_tick ? 20'h00000 : st.tick_cnt + 20'h00001;

        // Register writes land in the data phase
        if (st.dp_valid && st.dp_write) begin
            case (st.dp_addr)
                safety_gate_pkg::ADDR_CTRL: begin
                    next_st.cfg.latch_mon = hwdata[safety_gate_pkg::CTRL_LATCH_MON_BIT];
                    next_st.cfg.sys_mon = hwdata[safety_gate_pkg::CTRL_SYS_MON_BIT];
                end
                safety_gate_pkg::ADDR_LATCH: next_st.cfg.latch = hwdata[NI-1:0];
                safety_gate_pkg::ADDR_ESTOP: next_st.cfg.estop = hwdata[NI-1:0];
                safety_gate_pkg::ADDR_DELAY: begin
                    next_st.cfg.on_ms = hwdata[15:0];
                    next_st.cfg.off_ms = hwdata[safety_gate_pkg::DELAY_OFF_LSB +: 16];
                end
                safety_gate_pkg::ADDR_EN_LIMIT: begin
                    // Clamped, so the limit can never be switched off
                    if (lim < safety_gate_pkg::EN_LIMIT_MIN_MS) begin
                        next_st.cfg.en_limit = safety_gate_pkg::EN_LIMIT_MIN_MS;
                    end else if (lim > safety_gate_pkg::EN_LIMIT_MAX_MS) begin
                        next_st.cfg.en_limit = safety_gate_pkg::EN_LIMIT_MAX_MS;
                    end else begin
                        next_st.cfg.en_limit = lim;
                    end
                end
                default: begin
                    for (int o = 0; o < NO; o++) begin
                        if (st.dp_addr == safety_gate_pkg::ADDR_MAP_BASE + 8'(4 * o)) begin
                            next_st.cfg.map[o] = hwdata[11:0];
                        end
                    end
                end
            endcase
        end

        // Reset buttons: index 0 is the latch reset, 1 the system reset
        for (int i = 0; i < 2; i++) begin
            rst_lvl = pins[NI + i];
            rst_mon = (i == 0) ? st.cfg.latch_mon : st.cfg.sys_mon;
            if (rst_lvl) begin
                if (ms_tick && st.rst_ms[i] != safety_gate_pkg::RESET_SAT_MS) begin
                    next_st.rst_ms[i] = st.rst_ms[i] + 12'h001;
                end
                if (!rst_mon && !st.rst_fired[i]
                        && st.rst_ms[i] >= safety_gate_pkg::RESET_MIN_MS) begin
                    rst_pulse[i] = 1'b1;
                    next_st.rst_fired[i] = 1'b1;
                end
            end else begin
                if (rst_mon && st.rst_hi[i] && st.rst_ms[i] >= safety_gate_pkg::RESET_MIN_MS
                        && st.rst_ms[i] <= safety_gate_pkg::RESET_MAX_MS) begin
                    rst_pulse[i] = 1'b1;
                end
                next_st.rst_ms[i] = 12'h000;
                next_st.rst_fired[i] = 1'b0;
            end
            next_st.rst_hi[i] = rst_lvl;
        end

        // Two-hand sequencing; a late second hand forces a full release
        case (st.dual_actuator_control)
            safety_gate_pkg::THC_WAIT_RELEASE: begin
                if (ms_tick && !hand_a && !hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_IDLE;
                end
            end
            safety_gate_pkg::THC_IDLE: begin
                next_st.thc_ms = 12'h000;
                if (hand_a && hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_RUN;
                end else if (hand_a || hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_WINDOW;
                end
            end
            safety_gate_pkg::THC_WINDOW: begin
                if (!hand_a && !hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_IDLE;
                end else if (hand_a && hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_RUN;
                end else if (ms_tick) begin
                    if (st.thc_ms == safety_gate_pkg::TWO_HAND_WINDOW_MS) begin
                        next_st.dual_actuator_control = safety_gate_pkg::THC_WAIT_RELEASE;
                    end else begin
                        next_st.thc_ms = st.thc_ms + 12'h001;
                    end
                end
            end
            safety_gate_pkg::THC_RUN: begin
                if (!hand_a && !hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_IDLE;
                end else if (!hand_a || !hand_b) begin
                    next_st.dual_actuator_control = safety_gate_pkg::THC_WAIT_RELEASE;
                end
            end
            default: next_st.dual_actuator_control = safety_gate_pkg::THC_WAIT_RELEASE;
        endcase
        thc_enter = (next_st.dual_actuator_control == safety_gate_pkg::THC_RUN)
                    && (st.dual_actuator_control != safety_gate_pkg::THC_RUN);

        // Enable mode: entered on every rising edge, left only when off and reset
        sw_rise = sw_on && !st.sw_prev;
        next_st.sw_prev = sw_on;
        if (sw_rise) begin
            next_st.en_mode = 1'b1;
            next_st.en_left = st.cfg.en_limit;
        end else if (st.en_mode && sw_on && ms_tick && st.en_left != 21'h000000) begin
            next_st.en_left = st.en_left - 21'h000001;
        end
        if (st.en_mode && !sw_on && rst_pulse[1]) begin
            next_st.en_mode = 1'b0;
        end
        en_live = st.en_mode && sw_on && (st.en_left != 21'h000000);

        for (int o = 0; o < NO; o++) begin
            map = st.cfg.map[o];
            all_run = &(run | ~map[NI-1:0]);
            has_latch = |(map[NI-1:0] & st.cfg.latch);
            latch_stop = |(map[NI-1:0] & st.cfg.latch & ~run);
            // Stop of a latch input wins over a reset in the same cycle
            next_st.pending[o] = latch_stop
                                 | (st.pending[o] & ~(rst_pulse[0] & all_run));
            normal_ok = selfcheck_ok && all_run && !(st.pending[o] && has_latch);

            // Hands carry no latch of their own and must come last
            next_st.thc_ok[o] = (next_st.dual_actuator_control == safety_gate_pkg::THC_RUN) && normal_ok
                                && (st.thc_ok[o] || thc_enter);

            estop_ok = &(run | ~(map[NI-1:0] & st.cfg.estop));
            fb_closed = |(fb & map[MAP_FB_HI:safety_gate_pkg::MAP_FB_LSB]);
            next_st.en_hold[o] = en_live && estop_ok && selfcheck_ok
                                 && (st.en_hold[o] || fb_closed);

            if (map[safety_gate_pkg::MAP_ENSW_BIT] && st.en_mode) begin
                demand = st.en_hold[o];
            end else if (map[safety_gate_pkg::MAP_DUAL_BIT]) begin
                demand = st.thc_ok[o];
            end else begin
                demand = normal_ok;
            end

            // A self-check fault cuts the output without waiting for a delay
            target = demand ? st.cfg.on_ms : st.cfg.off_ms;
            if (!selfcheck_ok) begin
                next_st.out[o] = 1'b0;
                next_st.dly_ms[o] = 16'h0000;
            end else if (demand == st.out[o]) begin
                next_st.dly_ms[o] = 16'h0000;
            end else if (st.dly_ms[o] >= target) begin
                next_st.out[o] = demand;
                next_st.dly_ms[o] = 16'h0000;
            end else if (ms_tick) begin
                next_st.dly_ms[o] = st.dly_ms[o] + 16'h0001;
            end
        end

        // Address phase; read data is taken after the writes so it is never stale
        next_st.dp_valid = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_st.dp_valid = 1'b1;
            next_st.dp_write = hwrite;
            next_st.dp_addr = haddr[7:0];
            if (!hwrite) begin
                next_st.rdata = rd_mux(next_st, haddr[7:0], pins);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign safety_out = st.out;
    assign enable_mode = st.en_mode;

endmodule : safety_output_gate

// ==== safety_gate_properties.sv ====
`timescale 1ns/10ps
module safety_gate_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [safety_gate_pkg::N_IN-1:0] safety_in,
    input wire logic system_reset_in,
    input wire logic enable_sw_in,
    input wire logic [safety_gate_pkg::N_FB-1:0] contactor_feedback_input,
    input wire logic selfcheck_ok,
    input wire logic [safety_gate_pkg::N_OUT-1:0] safety_out,
    input wire logic enable_mode
);
    logic [3:0] sr_age;
    logic [3:0] sw_age;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr_age <= 4'hF;
            sw_age <= 4'h0;
        end else begin
            sr_age <= system_reset_in ? 4'h0 : sr_age + {3'h0, sr_age != 4'hF};
            sw_age <= !enable_sw_in ? 4'h0 : sw_age + {3'h0, sw_age != 4'hF};
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence mode_enter;
        !enable_mode ##1 enable_mode;
    endsequence
    sequence guard_stopped;
        (!enable_mode && !safety_in[1]) [*8];
    endsequence
    sequence enabled_rise;
        enable_mode && $rose(safety_out[0]);
    endsequence
    reset_outs_a: assert property ($rose(hresetn) |-> safety_out == '0 && !enable_mode)
        else $error("outputs or mode active after reset");
    selfcheck_off_a: assert property (!selfcheck_ok |=> safety_out == '0)
        else $error("output on after self-check fault");
    input_stop_a: assert property (guard_stopped |-> !safety_out[0])
        else $error("output on with a mapped input stopped");
    mode_entry_a: assert property (mode_enter |-> sw_age inside {[4'h2:4'h8]})
        else $error("mode entered without switch rise");
    mode_exit_a: assert property ($fell(enable_mode) |-> sr_age <= 4'hA && !enable_sw_in)
        else $error("mode left without switch off and reset");
    fb_start_a: assert property (enabled_rise |-> $past(contactor_feedback_input, 3) != '0)
        else $error("output on without feedback closed");
    switch_off_a: assert property ((enable_mode && !enable_sw_in) [*8] |-> !safety_out[0])
        else $error("output on with switch off");
    rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    bus_ready_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not OKAY");
endmodule : safety_gate_properties
bind safety_output_gate safety_gate_properties chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
    .hreadyout(hreadyout), .safety_in(safety_in), .system_reset_in(system_reset_in),
    .enable_sw_in(enable_sw_in), .contactor_feedback_input(contactor_feedback_input),
    .selfcheck_ok(selfcheck_ok), .safety_out(safety_out), .enable_mode(enable_mode));

// ==== field_devices.sv ====
`timescale 1ns/10ps
module field_devices #(
    parameter int MS = 20
) (
    input wire logic hclk,
    output logic [7:0] guards,
    output logic latch_btn,
    output logic sys_btn,
    output logic hand_a,
    output logic hand_b,
    output logic ensw,
    output logic [1:0] fb
);
    // Hands start held to test power-up release
    initial begin
        guards = 8'hFF;
        latch_btn = 1'b0;
        sys_btn = 1'b0;
        hand_a = 1'b1;
        hand_b = 1'b1;
        ensw = 1'b0;
        fb = 2'h0;
    end
    task automatic set_guards(input logic [7:0] g);
        @(posedge hclk);
        guards <= g;
    endtask : set_guards
    task automatic set_hands(input logic a, input logic b);
        @(posedge hclk);
        hand_a <= a;
        hand_b <= b;
    endtask : set_hands
    task automatic set_sw(input logic s);
        @(posedge hclk);
        ensw <= s;
    endtask : set_sw
    task automatic set_fb(input logic [1:0] f);
        @(posedge hclk);
        fb <= f;
    endtask : set_fb
    // Buttons have pull-downs, so a released button reads low
    task automatic press(input logic sys, input int ms);
        @(posedge hclk);
        if (sys) begin
            ensw <= 1'b0;
        end
        @(posedge hclk);
        latch_btn <= !sys;
        sys_btn <= sys;
        repeat (ms * MS) @(posedge hclk);
        latch_btn <= 1'b0;
        sys_btn <= 1'b0;
    endtask : press
endmodule : field_devices

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
    localparam int MS = 20;
    typedef struct {
        string name;
        logic [31:0] exp;
    } note_t;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, selfcheck_ok, enable_mode;
    logic latch_btn, sys_btn, hand_a, hand_b, ensw;
    logic [31:0] haddr, hwdata, hrdata, seen;
    logic [31:0] lfsr = 32'h73885547;
    logic [1:0] htrans, fb, safety_out;
    logic [7:0] guards;
    note_t notes[$];
    event result_ev;
    int mismatches = 0;
    int checks = 0;
    safety_output_gate #(.TICK_CYCLES(MS)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .safety_in(guards), .latch_reset_in(latch_btn), .system_reset_in(sys_btn),
        .hand_a_in(hand_a), .hand_b_in(hand_b), .enable_sw_in(ensw),
        .contactor_feedback_input(fb), .selfcheck_ok(selfcheck_ok), .safety_out(safety_out),
        .enable_mode(enable_mode));
    field_devices #(.MS(MS)) dev (.hclk(hclk), .guards(guards), .latch_btn(latch_btn),
        .sys_btn(sys_btn), .hand_a(hand_a), .hand_b(hand_b), .ensw(ensw), .fb(fb));
    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    function automatic logic [31:0] next_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_lfsr
    task automatic end_of_test();
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    always @(result_ev) begin
        note_t n;
        n = notes.pop_front();
        check(n.name, seen, n.exp);
    end
    task automatic note(input string name, input logic [31:0] e, input logic [31:0] s);
        notes.push_back('{name, e});
        seen = s;
        -> result_ev;
        #1;
    endtask : note
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask : wait_ready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        note($sformatf("reg %h", a), e, hrdata);
    endtask : rd
    // Ten cycles cover synchronisers and output register
    task automatic expect_out(input logic [1:0] o, input logic m);
        repeat (10) @(posedge hclk);
        note("outputs", {29'h0, m, o}, {29'h0, enable_mode, safety_out});
    endtask : expect_out
    task automatic wait_ms(input int n);
        repeat (n * MS) @(posedge hclk);
    endtask : wait_ms
    task automatic sc(input logic v);
        @(posedge hclk);
        selfcheck_ok <= v;
    endtask : sc
    initial begin
        repeat (90000) @(posedge hclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        selfcheck_ok = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        expect_out(2'h0, 1'b0);
        rd(8'h00, 32'h3);
        rd(8'h04, 32'hFF);
        rd(8'h24, 32'hFF);
        rd(8'h14, 32'h30000);
        rd(8'h1C, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_lfsr(lfsr);
            wr(8'h0C, lfsr);
            rd(8'h0C, lfsr);
        end
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h1);
        rd(8'h10, 32'h3E8);
        wr(8'h10, 32'h1FFFFF);
        rd(8'h10, 32'h1B7740);
        wr(8'h10, 32'h3E8);
        wr(8'h04, 32'h5);
        wr(8'h08, 32'h2);
        wr(8'h20, 32'h7);
        wr(8'h24, 32'h103);
        expect_out(2'h0, 1'b0);
        dev.set_guards(8'hFD);
        dev.press(1'b0, 400);
        dev.set_guards(8'hFF);
        expect_out(2'h0, 1'b0);
        dev.press(1'b0, 400);
        expect_out(2'h1, 1'b0);
        sc(1'b0);
        expect_out(2'h0, 1'b0);
        sc(1'b1);
        expect_out(2'h1, 1'b0);
        dev.set_guards(8'hFD);
        expect_out(2'h0, 1'b0);
        dev.set_guards(8'hFF);
        expect_out(2'h1, 1'b0);
        dev.set_guards(8'hFA);
        wait_ms(1);
        dev.set_guards(8'hFF);
        expect_out(2'h0, 1'b0);
        dev.set_hands(1'b0, 1'b0);
        dev.press(1'b0, 100);
        dev.set_hands(1'b1, 1'b1);
        expect_out(2'h0, 1'b0);
        dev.press(1'b0, 400);
        expect_out(2'h1, 1'b0);
        dev.set_hands(1'b0, 1'b0);
        wait_ms(1);
        dev.set_hands(1'b1, 1'b0);
        wait_ms(510);
        dev.set_hands(1'b1, 1'b1);
        expect_out(2'h1, 1'b0);
        dev.set_hands(1'b0, 1'b0);
        wait_ms(1);
        dev.set_hands(1'b1, 1'b0);
        wait_ms(100);
        dev.set_hands(1'b1, 1'b1);
        expect_out(2'h3, 1'b0);
        dev.set_guards(8'hFD);
        wait_ms(1);
        dev.set_guards(8'hFF);
        expect_out(2'h1, 1'b0);
        dev.set_hands(1'b0, 1'b0);
        wr(8'h20, 32'h603);
        dev.set_guards(8'hFE);
        expect_out(2'h0, 1'b0);
        dev.set_sw(1'b1);
        dev.set_fb(2'h1);
        expect_out(2'h1, 1'b1);
        dev.set_guards(8'hFC);
        expect_out(2'h0, 1'b1);
        dev.set_guards(8'hFE);
        expect_out(2'h1, 1'b1);
        dev.set_fb(2'h0);
        wait_ms(500);
        expect_out(2'h1, 1'b1);
        dev.set_sw(1'b0);
        expect_out(2'h0, 1'b1);
        dev.set_fb(2'h1);
        dev.set_sw(1'b1);
        wait_ms(980);
        expect_out(2'h1, 1'b1);
        wait_ms(40);
        expect_out(2'h0, 1'b1);
        wr(8'h00, 32'h1);
        dev.press(1'b1, 350);
        expect_out(2'h0, 1'b0);
        end_of_test();
    end
endmodule : tb
